// file: hw/panel_ctl_map.vh
// register offsets, field widths and reset values of the panel control strobe timing block
`ifndef PANEL_CTL_MAP_VH
`define PANEL_CTL_MAP_VH
`define CTL_STROBE_WIDTH_OFS    8'ha0
`define SEQ1_RISE_DELAY_OFS     8'ha4
`define SEQ2_RISE_DELAY_OFS     8'ha8
`define SEQ2_TOGGLE_WIDTH_OFS   8'hac
`define SEQ3_PULSE_WIDTH_OFS    8'hb0
`define POLARITY_FLIP_WIDTH_OFS 8'hb4
`define CTL_STROBE_WIDTH_BITS   9
`define SEQ1_RISE_DELAY_BITS    6
`define SEQ2_RISE_DELAY_BITS    8
`define SEQ2_TOGGLE_WIDTH_BITS  7
`define SEQ3_PULSE_WIDTH_BITS   7
`define POLARITY_FLIP_BITS      5
`define CTL_STROBE_WIDTH_RST    9'h00c
`define SEQ1_RISE_DELAY_RST     6'h32
`define SEQ2_RISE_DELAY_RST     8'h64
`define SEQ2_TOGGLE_WIDTH_RST   7'h0a
`define SEQ3_PULSE_WIDTH_RST    7'h64
`define POLARITY_FLIP_RST       5'h0a
`define AXI_RESP_OKAY           2'h0
`define AXI_RESP_SLVERR         2'h2
`endif

// file: hw/pulse_timer.v
// one-shot pixel clock timer: waits a delay, then holds its output for a width
`timescale 1ns/1ns
`default_nettype none
module pulse_timer #(
  parameter W = 9
) (
  input  wire         clk,
  input  wire         reset,
  input  wire         start,
  input  wire [W-1:0] delay,
  input  wire [W-1:0] width,
  output reg          busy,
  output reg          done
);
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_HIGH = 3'h4;

  reg [2:0]   state_reg;
  reg [W-1:0] count_reg;

  // a start while running restarts the sequence so each line gets a fresh pulse
  always @(posedge clk) begin
    done <= 1'b0;
    if (reset) begin
      state_reg <= S_IDLE;
      count_reg <= {W{1'b0}};
      busy      <= 1'b0;
    end else if (start) begin
      busy <= 1'b0;
      if (delay == {W{1'b0}}) begin
        state_reg <= S_HIGH;
        count_reg <= width;
        busy      <= (width != {W{1'b0}});
      end else begin
        state_reg <= S_WAIT;
        count_reg <= delay;
      end
    end else begin
      case (state_reg)
        S_WAIT: begin
          if (count_reg == {{(W-1){1'b0}}, 1'b1}) begin
            state_reg <= S_HIGH;
            count_reg <= width;
            busy      <= (width != {W{1'b0}});
          end else begin
            count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
          end
        end
        S_HIGH: begin
          // zero width is illegal; treat it as an immediate end
          if (count_reg <= {{(W-1){1'b0}}, 1'b1}) begin
            state_reg <= S_IDLE;
            busy      <= 1'b0;
            done      <= 1'b1;
          end else begin
            count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
          end
        end
        S_IDLE: state_reg <= S_IDLE;
        default: begin
          state_reg <= S_IDLE;
          busy      <= 1'b0;
        end
      endcase
    end
  end
endmodule // pulse_timer
`default_nettype wire

// file: hw/panel_ctl_signal_timing.v
// panel control strobe and power sequence timing generator with an AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "panel_ctl_map.vh"

// How it works
// - control strobe high for programmed width
// - first power signal rises delay after strobe
// - second power signal rises delay after line
// - second power signal toggles after programmed width
// - third power signal pulses programmed width
// - polarity flip toggles width before line rises
module panel_ctl_signal_timing (
  input  wire        clk,
  input  wire        reset,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        line_pulse,
  input  wire [15:0] line_total,
  output reg         panel_ctl_strobe,
  output reg         power_seq_first,
  output reg         power_seq_second,
  output reg         power_seq_third,
  output reg         polarity_flip_signal,
  output reg         line_active
);
  // timing fields, each held only at its documented width
  reg [8:0] ctl_strobe_width_reg;
  reg [5:0] seq1_rise_delay_reg;
  reg [7:0] seq2_rise_delay_reg;
  reg [6:0] seq2_toggle_width_reg;
  reg [6:0] seq3_pulse_width_reg;
  reg [4:0] polarity_flip_width_reg;

  // write channel latches: address and data may arrive in either order
  reg [7:0]  wr_addr_reg;
  reg [31:0] wr_data_reg;
  reg [3:0]  wr_strb_reg;
  reg        wr_addr_ok_reg;
  reg        wr_data_ok_reg;

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `CTL_STROBE_WIDTH_OFS) || (a == `SEQ1_RISE_DELAY_OFS) ||
               (a == `SEQ2_RISE_DELAY_OFS) || (a == `SEQ2_TOGGLE_WIDTH_OFS) ||
               (a == `SEQ3_PULSE_WIDTH_OFS) || (a == `POLARITY_FLIP_WIDTH_OFS);
    end
  endfunction

  // merge the two low byte lanes into the nine-bit strobe width; no other lane reaches it
  function [8:0] merge;
    input [8:0]  old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge = {s[1] ? d[8] : old[8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  wire do_write = wr_addr_ok_reg && wr_data_ok_reg && !s_axi_bvalid;

  // write address, data and response
  always @(posedge clk) begin
    if (reset) begin
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= `AXI_RESP_OKAY;
      wr_addr_ok_reg <= 1'b0;
      wr_data_ok_reg <= 1'b0;
      wr_addr_reg    <= 8'h00;
      wr_data_reg    <= 32'h00000000;
      wr_strb_reg    <= 4'h0;
    end else begin
      s_axi_awready <= !wr_addr_ok_reg && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !wr_data_ok_reg && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_ok_reg <= 1'b1;
        wr_addr_reg    <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_ok_reg <= 1'b1;
        wr_data_reg    <= s_axi_wdata;
        wr_strb_reg    <= s_axi_wstrb;
      end
      if (do_write) begin
        wr_addr_ok_reg <= 1'b0;
        wr_data_ok_reg <= 1'b0;
        s_axi_bvalid   <= 1'b1;
        s_axi_bresp    <= mapped(wr_addr_reg) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register file; upper bits of each word are simply not stored
  always @(posedge clk) begin
    if (reset) begin
      ctl_strobe_width_reg    <= `CTL_STROBE_WIDTH_RST;
      seq1_rise_delay_reg     <= `SEQ1_RISE_DELAY_RST;
      seq2_rise_delay_reg     <= `SEQ2_RISE_DELAY_RST;
      seq2_toggle_width_reg   <= `SEQ2_TOGGLE_WIDTH_RST;
      seq3_pulse_width_reg    <= `SEQ3_PULSE_WIDTH_RST;
      polarity_flip_width_reg <= `POLARITY_FLIP_RST;
    end else if (do_write) begin
      case (wr_addr_reg)
        `CTL_STROBE_WIDTH_OFS: ctl_strobe_width_reg <=
          merge(ctl_strobe_width_reg, wr_data_reg, wr_strb_reg);
        `SEQ1_RISE_DELAY_OFS: if (wr_strb_reg[0]) seq1_rise_delay_reg <= wr_data_reg[5:0];
        `SEQ2_RISE_DELAY_OFS: if (wr_strb_reg[0]) seq2_rise_delay_reg <= wr_data_reg[7:0];
        `SEQ2_TOGGLE_WIDTH_OFS: if (wr_strb_reg[0]) seq2_toggle_width_reg <= wr_data_reg[6:0];
        `SEQ3_PULSE_WIDTH_OFS: if (wr_strb_reg[0]) seq3_pulse_width_reg <= wr_data_reg[6:0];
        `POLARITY_FLIP_WIDTH_OFS: if (wr_strb_reg[0]) polarity_flip_width_reg <= wr_data_reg[4:0];
        default: ctl_strobe_width_reg <= ctl_strobe_width_reg;
      endcase
    end
  end

  // read channel: one cycle to accept, data on the next
  always @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `AXI_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped({s_axi_araddr[7:2], 2'b00}) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        case ({s_axi_araddr[7:2], 2'b00})
          `CTL_STROBE_WIDTH_OFS:    s_axi_rdata <= {23'h0, ctl_strobe_width_reg};
          `SEQ1_RISE_DELAY_OFS:     s_axi_rdata <= {26'h0, seq1_rise_delay_reg};
          `SEQ2_RISE_DELAY_OFS:     s_axi_rdata <= {24'h0, seq2_rise_delay_reg};
          `SEQ2_TOGGLE_WIDTH_OFS:   s_axi_rdata <= {25'h0, seq2_toggle_width_reg};
          `SEQ3_PULSE_WIDTH_OFS:    s_axi_rdata <= {25'h0, seq3_pulse_width_reg};
          `POLARITY_FLIP_WIDTH_OFS: s_axi_rdata <= {27'h0, polarity_flip_width_reg};
          default:                  s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // line pulse arrives from another timing source: two flops before use
  reg lp_meta_reg;
  reg lp_sync_reg;
  reg lp_prev_reg;
  always @(posedge clk) begin
    if (reset) begin
      lp_meta_reg <= 1'b0;
      lp_sync_reg <= 1'b0;
      lp_prev_reg <= 1'b0;
    end else begin
      lp_meta_reg <= line_pulse;
      lp_sync_reg <= lp_meta_reg;
      lp_prev_reg <= lp_sync_reg;
    end
  end
  wire lp_fall = lp_prev_reg && !lp_sync_reg;

  // line period measured in pixel clocks, so the flip can lead the next rise
  reg [15:0] line_cnt_reg;
  always @(posedge clk) begin
    if (reset || lp_fall)
      line_cnt_reg <= 16'h0000;
    else
      line_cnt_reg <= line_cnt_reg + 16'h0001;
  end

  // strobe starts at line pulse fall
  wire strobe_busy;
  wire strobe_done;
  pulse_timer #(.W(9)) u_strobe (
    .clk   (clk),
    .reset (reset),
    .start (lp_fall),
    .delay (9'h000),
    .width (ctl_strobe_width_reg),
    .busy  (strobe_busy),
    .done  (strobe_done)
  );

  // first power signal: counts from strobe fall, then stays high for the line
  reg [5:0] seq1_cnt_reg;
  reg       seq1_wait_reg;
  always @(posedge clk) begin
    if (reset || lp_fall) begin
      seq1_cnt_reg    <= 6'h00;
      seq1_wait_reg   <= 1'b0;
      power_seq_first <= 1'b0;
    end else if (strobe_done) begin
      seq1_cnt_reg    <= seq1_rise_delay_reg;
      seq1_wait_reg   <= (seq1_rise_delay_reg != 6'h00);
      power_seq_first <= (seq1_rise_delay_reg == 6'h00);
    end else if (seq1_wait_reg) begin
      if (seq1_cnt_reg == 6'h01) begin
        seq1_wait_reg   <= 1'b0;
        power_seq_first <= 1'b1;
      end
      seq1_cnt_reg <= seq1_cnt_reg - 6'h01;
    end
  end

  // second power signal: first rise after delay, then toggles every width
  reg [7:0] seq2_cnt_reg;
  reg       seq2_run_reg;
  reg       seq2_wait_reg;
  always @(posedge clk) begin
    if (reset || lp_fall) begin
      seq2_cnt_reg     <= reset ? 8'h00 : seq2_rise_delay_reg;
      seq2_wait_reg    <= !reset;
      seq2_run_reg     <= 1'b0;
      power_seq_second <= 1'b0;
    end else if (seq2_wait_reg) begin
      if (seq2_cnt_reg <= 8'h01) begin
        seq2_wait_reg    <= 1'b0;
        seq2_run_reg     <= 1'b1;
        power_seq_second <= 1'b1;
        seq2_cnt_reg     <= {1'b0, seq2_toggle_width_reg};
      end else begin
        seq2_cnt_reg <= seq2_cnt_reg - 8'h01;
      end
    end else if (seq2_run_reg) begin
      if (seq2_cnt_reg <= 8'h01) begin
        power_seq_second <= !power_seq_second;
        seq2_cnt_reg     <= {1'b0, seq2_toggle_width_reg};
      end else begin
        seq2_cnt_reg <= seq2_cnt_reg - 8'h01;
      end
    end
  end

  // third power signal: one pulse per line as the first signal rises
  reg  seq1_prev_reg;
  wire seq3_busy;
  always @(posedge clk) begin
    if (reset)
      seq1_prev_reg <= 1'b0;
    else
      seq1_prev_reg <= power_seq_first;
  end
  pulse_timer #(.W(7)) u_seq3 (
    .clk   (clk),
    .reset (reset),
    .start (power_seq_first && !seq1_prev_reg),
    .delay (7'h00),
    .width (seq3_pulse_width_reg),
    .busy  (seq3_busy),
    .done  ()
  );

  // flip window: last width clocks before the line pulse rises
  wire [15:0] flip_start = line_total - {11'h000, polarity_flip_width_reg};

  // registered outputs
  always @(posedge clk) begin
    if (reset) begin
      panel_ctl_strobe     <= 1'b0;
      power_seq_third      <= 1'b0;
      polarity_flip_signal <= 1'b0;
      line_active          <= 1'b0;
    end else begin
      panel_ctl_strobe <= strobe_busy;
      power_seq_third  <= seq3_busy;
      line_active      <= !lp_sync_reg && (line_active || lp_fall); // no line before a seen fall
      if (lp_fall)
        polarity_flip_signal <= 1'b0;
      else if (polarity_flip_width_reg != 5'h00 && line_cnt_reg >= flip_start &&
               line_cnt_reg < line_total)
        polarity_flip_signal <= !polarity_flip_signal;
    end
  end
endmodule // panel_ctl_signal_timing
`default_nettype wire

// file: tb/panel_ctl_monitor.sv
// assertion checker for the panel control timing block
`timescale 1ns/1ns
`default_nettype none
`include "panel_ctl_map.vh"
module panel_ctl_monitor (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        line_active,
  input wire logic        panel_ctl_strobe,
  input wire logic        power_seq_first,
  input wire logic        power_seq_third
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready held");
  AST_READ_ANSWER: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_SLVERR_ZERO: assert property (
    s_axi_rvalid && s_axi_rresp == `AXI_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  AST_STROBE_START: assert property (
    $rose(line_active) |-> ##[1:4] panel_ctl_strobe) else $error("strobe missing");
  AST_SEQ1_QUIET: assert property (
    $rose(power_seq_first) |-> !panel_ctl_strobe) else $error("first rose in strobe");
  AST_SEQ3_FOLLOW: assert property (
    $rose(power_seq_first) |-> ##[0:2] power_seq_third) else $error("third missing");
  // main scenarios reached
  cover property ($fell(panel_ctl_strobe));
  cover property (s_axi_rvalid && s_axi_rresp == `AXI_RESP_SLVERR);
  cover property ($fell(power_seq_third));
endmodule // panel_ctl_monitor
bind panel_ctl_signal_timing panel_ctl_monitor i_mon (.clk, .reset, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .line_active, .panel_ctl_strobe,
  .power_seq_first, .power_seq_third);
`default_nettype wire

// file: tb/panel_model.sv
// panel side model: measures strobe and power sequence timing of each line
`timescale 1ns/1ns
`default_nettype none
module panel_model (
  input  wire logic clk,
  input  wire logic line_active,
  input  wire logic panel_ctl_strobe,
  input  wire logic power_seq_first,
  input  wire logic power_seq_second,
  input  wire logic power_seq_third,
  input  wire logic polarity_flip_signal,
  output var  int   meas [6]
);
  logic       s_q, p1_q, p2_q, f_q;
  logic [3:0] st;
  wire        sf = s_q && !panel_ctl_strobe;
  wire        r2 = !p2_q && power_seq_second;
  // counts restart each line; the panel only listens, it drives nothing back
  always @(posedge clk) begin
    {s_q, p1_q, p2_q, f_q} <= {panel_ctl_strobe, power_seq_first, power_seq_second,
                               polarity_flip_signal};
    if (!line_active) begin
      meas <= '{default: 0};
      st   <= 4'h0;
      {s_q, p1_q, p2_q, f_q} <= 4'h0; // leftovers of the last line must not look like edges
    end else begin
      if (sf) st[0] <= 1'b1;
      if (!p1_q && power_seq_first) st[1] <= 1'b1;
      if (r2) st[2] <= 1'b1;
      if (p2_q && !power_seq_second) st[3] <= 1'b1;
      meas[0] <= meas[0] + int'(panel_ctl_strobe);
      meas[1] <= meas[1] + int'((st[0] || sf) && !st[1] && !power_seq_first);
      meas[2] <= meas[2] + int'(!st[2] && !r2);
      meas[3] <= meas[3] + int'((st[2] || r2) && !st[3] && power_seq_second);
      meas[4] <= meas[4] + int'(power_seq_third);
      meas[5] <= meas[5] + int'(polarity_flip_signal != f_q);
    end
  end
endmodule // panel_model
`default_nettype wire

// file: tb/tb_top.sv
// register and line timing testbench of the panel control timing block
`timescale 1ns/1ns
`default_nettype none
`include "panel_ctl_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
  logic        clk, reset, line_pulse;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] line_total;
  logic        panel_ctl_strobe, power_seq_first, power_seq_second;
  logic        power_seq_third, polarity_flip_signal, line_active;
  int          n_fail, n_checks, i, d2a, lag;
  int          meas [6];
  int          got [6];
  logic [7:0]  ofs [6] = '{`CTL_STROBE_WIDTH_OFS, `SEQ1_RISE_DELAY_OFS,
    `SEQ2_RISE_DELAY_OFS, `SEQ2_TOGGLE_WIDTH_OFS, `SEQ3_PULSE_WIDTH_OFS,
    `POLARITY_FLIP_WIDTH_OFS};
  logic [31:0] msk [6] = '{32'h1ff, 32'h3f, 32'hff, 32'h7f, 32'h7f, 32'h1f};
  logic [31:0] rst [6] = '{32'h00c, 32'h32, 32'h64, 32'h0a, 32'h64, 32'h0a};

  panel_ctl_signal_timing i_dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .line_pulse, .line_total, .panel_ctl_strobe, .power_seq_first,
    .power_seq_second, .power_seq_third, .polarity_flip_signal, .line_active);
  panel_model i_panel (.clk, .line_active, .panel_ctl_strobe, .power_seq_first,
    .power_seq_second, .power_seq_third, .polarity_flip_signal, .meas);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // write with both channels offered together; bready raised after lag edges, held until answer
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int t;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'b11, lag == 0};
    for (t = 0; t < 50 && !(s_axi_bvalid && s_axi_bready); t++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (t + 1 >= lag) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bvalid, 1'b1)
    `CHK(s_axi_bresp, e)
    @(posedge clk);
  endtask

  // a late rready keeps the answer waiting, so the hold rules get exercised
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int t;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 1'b1, lag == 0};
    for (t = 0; t < 50 && !(s_axi_rvalid && s_axi_rready); t++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (t + 1 >= lag) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rvalid, 1'b1)
    `CHK(s_axi_rdata, e)
    `CHK(s_axi_rresp, r)
    @(posedge clk);
  endtask

  // one line: the measurements are taken before the line pulse rises again
  task automatic run_line(input logic [31:0] v [6]);
    for (int k = 0; k < 6; k++) axi_wr(ofs[k], v[k], `AXI_RESP_OKAY);
    line_pulse <= 1'b0;
    repeat (420) @(posedge clk);
    got = meas;
    line_pulse <= 1'b1;
    repeat (20) @(posedge clk);
  endtask

  task give_verdict;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    {n_fail, n_checks, lag} = '0;
    {reset, line_pulse, line_total, s_axi_wstrb} = {2'b11, 16'd400, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 6; i++) axi_rd(ofs[i], rst[i], `AXI_RESP_OKAY);
    $display("reset values done");
    for (i = 0; i < 6; i++) axi_wr(ofs[i], 32'hffffffff, `AXI_RESP_OKAY);
    for (i = 0; i < 6; i++) axi_rd(ofs[i], msk[i], `AXI_RESP_OKAY);
    lag = 4;
    axi_wr(8'hc0, 32'h1, `AXI_RESP_SLVERR);
    axi_rd(8'hc0, 32'h0, `AXI_RESP_SLVERR);
    lag = 0;
    $display("register access done");
    run_line('{32'd5, 32'd3, 32'd4, 32'd3, 32'd6, 32'd4});
    `CHK(got[0], 5)
    `CHK(got[1], 3)
    `CHK(got[3], 3)
    `CHK(got[4], 6)
    `CHK(got[5], 4)
    d2a = got[2];
    $display("short line done");
    run_line('{32'h101, 32'd7, 32'd9, 32'd5, 32'd2, 32'd9});
    `CHK(got[0], 257)
    `CHK(got[1], 7)
    `CHK(got[2] - d2a, 5)
    `CHK(got[3], 5)
    `CHK(got[4], 2)
    `CHK(got[5], 9)
    $display("long strobe line done");
    give_verdict();
  end

  // watchdog sized well beyond the two lines and the register traffic
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
